// ===== afp_assertions.sv
// checker: port-level assertions for the fault protection block
`timescale 1ns/1ps
`default_nettype none
module afp_assertions
  import afp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic abort_n_i,
  input wire logic watchdog_i,
  input wire logic [AFP_AXES-1:0] fwd_limit_i,
  input wire logic [AFP_AXES-1:0] target_vld_i,
  input wire logic [AFP_AXES-1:0] target_acc_o,
  input wire logic [AFP_AXES-1:0] target_rej_o,
  input wire logic [AFP_AXES-1:0] inhibit_fwd_o,
  input wire logic [AFP_AXES-1:0] hard_stop_o,
  input wire logic [AFP_AXES-1:0] amp_enable_out_o,
  input wire logic error_n_o,
  input wire logic error_led_o
);
  logic fpol_ff; // shadow of forward polarity, lags the design by one cycle
  // shadow follows completed writes to the control word
  always_ff @(posedge clk_i) begin
    if (rst_i) fpol_ff <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == AFP_REG_CTRL) fpol_ff <= wb_dat_i[AFP_CTRL_FPOL];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // seven cycles covers the pin synchroniser plus output flop
  sequence abort_held_s; !abort_n_i [*7]; endsequence
  sequence fwd_held_s; (fwd_limit_i[0] == fpol_ff) [*7]; endsequence
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_off_a: assert property (disable iff (1'b0) rst_i && ce_i |=> !amp_enable_out_o && error_n_o)
    else $error("amp on after reset");
  watchdog_off_a: assert property (watchdog_i && ce_i |=> amp_enable_out_o == '0)
    else $error("amp on after watchdog");
  err_pair_a: assert property (error_n_o != error_led_o)
    else $error("error pin and led disagree");
  target_excl_a: assert property (target_vld_i[0] && ce_i |=> target_acc_o[0] ^ target_rej_o[0])
    else $error("target not judged once");
  abort_stop_a: assert property (abort_held_s |-> hard_stop_o == '1 && !error_n_o)
    else $error("abort pin not stopping");
  fwd_inhibit_a: assert property (fwd_held_s |-> inhibit_fwd_o[0])
    else $error("forward limit not inhibiting");
endmodule : afp_assertions
`default_nettype wire

// ===== afp_partner.sv
// partner: encoders following the servo and low-active travel switches
`timescale 1ns/1ps
`default_nettype none
module afp_partner
  import afp_pkg::*;
#(
  parameter logic [31:0] SW_POS = 32'h0000_0800 // switch mark, plain default
) (
  input wire logic clk_i,
  input wire logic [AFP_AXES*AFP_POS_W-1:0] cmd_pos_i,
  input wire logic [AFP_AXES-1:0] amp_en_i,
  input wire logic [31:0] lag_i, // forced following error on axis 0
  output logic [AFP_AXES*AFP_POS_W-1:0] enc_pos_o,
  output logic [AFP_AXES-1:0] fwd_limit_o,
  output logic [AFP_AXES-1:0] rev_limit_o
);
  initial enc_pos_o = '0;
  // unpowered axes coast: encoder stays where it was
  always @(posedge clk_i) begin
    for (int i = 0; i < AFP_AXES; i++) begin
      if (amp_en_i[i]) enc_pos_o[i*32 +: 32] <= cmd_pos_i[i*32 +: 32] - (i == 0 ? lag_i : 32'h0);
    end
  end
  // switches pull low once the axis passes its mark
  always_comb begin
    for (int i = 0; i < AFP_AXES; i++) begin
      fwd_limit_o[i] = $signed(enc_pos_o[i*32 +: 32]) < $signed(SW_POS);
      rev_limit_o[i] = $signed(enc_pos_o[i*32 +: 32]) > -$signed(SW_POS);
    end
  end
endmodule : afp_partner
`default_nettype wire

// ===== afp_pkg.sv
// package: constants, register map and types for the axis fault protection block
package afp_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int AFP_AXES = 4;             // supervised axes
  localparam int AFP_POS_W = 32;           // position width, quadrature counts

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] AFP_REG_CTRL = 8'h00;      // config and commands
  localparam logic [7:0] AFP_REG_STATUS = 8'h04;    // fault and limit status
  localparam logic [7:0] AFP_REG_HANDLER = 8'h08;   // pending handler requests
  localparam logic [7:0] AFP_REG_AXSEL = 8'h0C;     // axis select for window
  localparam logic [7:0] AFP_REG_ERRLIM = 8'h10;    // error_limit of selected axis
  localparam logic [7:0] AFP_REG_SOFTFWD = 8'h14;   // soft_forward_limit
  localparam logic [7:0] AFP_REG_SOFTREV = 8'h18;   // soft_reverse_limit
  localparam logic [7:0] AFP_REG_ERRRD = 8'h1C;     // error_readback
  localparam logic [7:0] AFP_REG_OFFERR = 8'h20;    // off-on-error mode per axis

  // ctrl field positions
  localparam int AFP_CTRL_FPOL = 0;        // forward limit active high when 1
  localparam int AFP_CTRL_RPOL = 1;        // reverse limit active high when 1
  localparam int AFP_CTRL_ABORT = 2;       // abort command, self clearing
  localparam int AFP_CTRL_SOFTEN = 3;      // soft limits armed
  localparam int AFP_CTRL_SERVO = 8;       // servo_here_cmd, 4 bits, self clearing
  localparam int AFP_CTRL_RET = 12;        // handler_return_cmd, self clearing
  localparam int AFP_CTRL_LOCK = 13;       // electronic_lockout jumper fitted

  // reset values
  localparam logic [31:0] AFP_ERRLIM_RST = 32'h0000_4000;
  localparam logic [31:0] AFP_SOFTFWD_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] AFP_SOFTREV_RST = 32'h8000_0000;
  localparam logic [1:0] AFP_OFFERR_RST = 2'h0;

  // off-on-error mode codes
  localparam logic [1:0] AFP_OE_OFF = 2'h0;
  localparam logic [1:0] AFP_OE_ERR = 2'h1;      // setting 1: all faults
  localparam logic [1:0] AFP_OE_LIMIT = 2'h2;    // setting 2: limits and abort only
  localparam logic [1:0] AFP_OE_ALL = 2'h3;      // setting 3: all faults

  // handler states
  typedef enum logic [1:0] {
    AFP_H_IDLE,
    AFP_H_POS_ERROR_HANDLER,
    AFP_H_LIMIT,
    AFP_H_AMP
  } afp_hstate_t;

endpackage : afp_pkg

// ===== afp_sync.sv
// module: three stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module afp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ----------------------------------------
  // stages
  // ----------------------------------------
  logic [W-1:0] s1_ff; // metastable stage, read only by s2
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  // shift chain; accept a change once stage two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      q_ff <= '1;
    end else if (ce_i) begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          q_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign q_o = q_ff;
endmodule : afp_sync
`default_nettype wire

// ===== afp_top.sv
// module: per-axis fault protection supervisor with wishbone registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - active forward limit blocks forward motion
// - active reverse limit blocks reverse motion
// - forward limit while forward requests decelerated stop
// - reverse limit while reverse requests decelerated stop
// - limit handler only when moving toward limit
// - limit polarity selectable by configuration
// - off-on-error turns motor off at limit
// - flag error when abs error exceeds limit
// - excess error drops amp enable, lights indicator
// - excess error disables motor for setting 1,3
// - position error readable by host anytime
// - reject position targets beyond soft limits
// - stop motion crossing soft limits
// - abort with off-on-error disables motor
// - fault disable holds until servo here
// - error handler on error, encoder, abort
// - handler reentered until condition cleared; limit handler returns to idle regardless
// - lockout abort kills amp, amp handler
// - limit input states readable as status
// - abort pin stops motion at once
// - error output low while any error
// - amp enable off on watchdog or reset
module afp_top
  import afp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,                        // freezes all state when low
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic [AFP_AXES-1:0] fwd_limit_i,  // forward limit switch pins
  input wire logic [AFP_AXES-1:0] rev_limit_i,  // reverse limit switch pins
  input wire logic abort_n_i,                   // general abort pin, low active
  input wire logic [AFP_AXES-1:0] enc_fail_i,   // encoder failure from decoder
  input wire logic watchdog_i,                  // watchdog trip, same clock
  // motion side, same clock
  input wire logic [AFP_AXES*AFP_POS_W-1:0] cmd_pos_i,   // commanded positions
  input wire logic [AFP_AXES*AFP_POS_W-1:0] enc_pos_i,   // encoder positions
  input wire logic [AFP_AXES*AFP_POS_W-1:0] target_i,    // requested targets
  input wire logic [AFP_AXES-1:0] target_vld_i,          // target offered
  input wire logic [AFP_AXES-1:0] move_fwd_i,            // profiler moving forward
  input wire logic [AFP_AXES-1:0] move_rev_i,            // profiler moving reverse
  output logic [AFP_AXES-1:0] target_acc_o,              // target accepted
  output logic [AFP_AXES-1:0] target_rej_o,              // target rejected
  output logic [AFP_AXES-1:0] inhibit_fwd_o,             // no forward motion
  output logic [AFP_AXES-1:0] inhibit_rev_o,             // no reverse motion
  output logic [AFP_AXES-1:0] decel_stop_o,              // controlled stop
  output logic [AFP_AXES-1:0] hard_stop_o,               // instant stop
  output logic [AFP_AXES-1:0] amp_enable_out_o,          // high = amp enabled
  output logic error_n_o,                                // low = error
  output logic error_led_o,                              // error indicator
  output logic amp_kill_o                                // hardware amp shutdown
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic fpol_ff;                      // forward polarity
  logic rpol_ff;                      // reverse polarity
  logic soften_ff;                    // soft limits armed
  logic lock_ff;                      // lockout jumper state
  logic abort_cmd_ff;                 // one cycle abort command
  logic [AFP_AXES-1:0] servo_cmd_ff;  // one cycle servo here per axis
  logic ret_cmd_ff;                   // one cycle handler return
  logic [1:0] axsel_ff;               // window axis
  logic [31:0] errlim_ff [AFP_AXES];  // error limits
  logic [31:0] softfwd_ff [AFP_AXES]; // soft forward limits
  logic [31:0] softrev_ff [AFP_AXES]; // soft reverse limits
  logic [1:0] oe_ff [AFP_AXES];       // off-on-error modes

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  logic [AFP_AXES-1:0] fwd_pin;
  logic [AFP_AXES-1:0] rev_pin;
  logic abort_pin_n;

  afp_sync #(.W(2*AFP_AXES+1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({abort_n_i, rev_limit_i, fwd_limit_i}),
    .q_o({abort_pin_n, rev_pin, fwd_pin})
  );

  // ----------------------------------------
  // per axis combinational terms
  // ----------------------------------------
  logic [AFP_AXES-1:0] fwd_act;     // forward limit active
  logic [AFP_AXES-1:0] rev_act;     // reverse limit active
  logic [AFP_AXES-1:0] excess;      // position error over limit
  logic [AFP_AXES-1:0] soft_fwd;    // at or past soft forward
  logic [AFP_AXES-1:0] soft_rev;    // at or past soft reverse
  logic [AFP_AXES-1:0] tgt_bad;     // target outside soft window
  logic [AFP_AXES-1:0] hit_fwd;     // limit reached while moving forward
  logic [AFP_AXES-1:0] hit_rev;     // limit reached while moving reverse
  logic [AFP_AXES-1:0] oe_trip;     // off-on-error disable event
  logic [31:0] abs_err [AFP_AXES];  // absolute error per axis
  logic abort_any;                  // abort pin or command
  logic abort_pin_act;              // pin level abort

  assign abort_pin_act = ~abort_pin_n;
  assign abort_any = abort_pin_act | abort_cmd_ff;

  logic [AFP_AXES-1:0] fwd_pin_q;   // previous limit activity
  logic [AFP_AXES-1:0] rev_pin_q;

  genvar g;
  generate
    for (g = 0; g < AFP_AXES; g++) begin : g_ax
      logic signed [AFP_POS_W-1:0] cpos;
      logic signed [AFP_POS_W-1:0] epos;
      logic signed [AFP_POS_W-1:0] tpos;
      logic signed [AFP_POS_W-1:0] diff;
      assign cpos = cmd_pos_i[g*AFP_POS_W +: AFP_POS_W];
      assign epos = enc_pos_i[g*AFP_POS_W +: AFP_POS_W];
      assign tpos = target_i[g*AFP_POS_W +: AFP_POS_W];
      assign diff = cpos - epos;
      assign fwd_act[g] = fwd_pin[g] ~^ fpol_ff;
      assign rev_act[g] = rev_pin[g] ~^ rpol_ff;
      assign abs_err[g] = diff[AFP_POS_W-1] ? 32'(-diff) : 32'(diff);
      assign excess[g] = abs_err[g] > errlim_ff[g];
      assign soft_fwd[g] = soften_ff && (cpos >= $signed(softfwd_ff[g]));
      assign soft_rev[g] = soften_ff && (cpos <= $signed(softrev_ff[g]));
      assign tgt_bad[g] = soften_ff &&
        ((tpos > $signed(softfwd_ff[g])) || (tpos < $signed(softrev_ff[g])));
      // only moving toward the limit counts
      assign hit_fwd[g] = fwd_act[g] & ~fwd_pin_q[g] & move_fwd_i[g];
      assign hit_rev[g] = rev_act[g] & ~rev_pin_q[g] & move_rev_i[g];
      // limit disable in any nonzero mode
      // error disable only in settings 1 and 3
      // abort disable in any nonzero mode
      assign oe_trip[g] = (oe_ff[g] != AFP_OE_OFF) &&
        (fwd_act[g] || rev_act[g] || abort_any ||
         (excess[g] && (oe_ff[g] == AFP_OE_ERR || oe_ff[g] == AFP_OE_ALL)));
    end
  endgenerate

  // ----------------------------------------
  // limit edge history
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_pin_q <= '0;
      rev_pin_q <= '0;
    end else if (ce_i) begin
      fwd_pin_q <= fwd_act;
      rev_pin_q <= rev_act;
    end
  end

  // ----------------------------------------
  // motion gating outputs
  // ----------------------------------------
  logic [AFP_AXES-1:0] inh_fwd_ff;
  logic [AFP_AXES-1:0] inh_rev_ff;
  logic [AFP_AXES-1:0] decel_ff;
  logic [AFP_AXES-1:0] hard_ff;
  logic [AFP_AXES-1:0] acc_ff;
  logic [AFP_AXES-1:0] rej_ff;

  // inhibit, stop kind and target screening
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inh_fwd_ff <= '0;
      inh_rev_ff <= '0;
      decel_ff <= '0;
      hard_ff <= '0;
      acc_ff <= '0;
      rej_ff <= '0;
    end else if (ce_i) begin
      inh_fwd_ff <= fwd_act | soft_fwd;
      inh_rev_ff <= rev_act | soft_rev;
      decel_ff <= (fwd_act & move_fwd_i) | (rev_act & move_rev_i) |
                  (soft_fwd & move_fwd_i) | (soft_rev & move_rev_i);
      // abort pin halts at once, on every axis
      hard_ff <= {AFP_AXES{abort_pin_act}};
      acc_ff <= target_vld_i & ~tgt_bad;
      rej_ff <= target_vld_i & tgt_bad;
    end
  end

  // ----------------------------------------
  // amplifier enable per axis
  // ----------------------------------------
  logic [AFP_AXES-1:0] amp_en_ff;
  logic amp_kill_ff;
  logic lock_kill;

  // hardware lockout path ignores software state
  assign lock_kill = lock_ff & abort_pin_act;

  // sticky disable; only servo here brings an axis back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_en_ff <= '0;
      amp_kill_ff <= 1'b0;
    end else if (ce_i) begin
      amp_kill_ff <= lock_kill;
      for (int i = 0; i < AFP_AXES; i++) begin
        // each axis on its own faults; watchdog and lockout drop every axis
        if (watchdog_i || excess[i] || oe_trip[i] || lock_kill) begin
          amp_en_ff[i] <= 1'b0;
        end else if (servo_cmd_ff[i]) begin
          amp_en_ff[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // error indicator
  // ----------------------------------------
  logic err_led_ff;
  logic err_n_ff;

  // any error condition lights both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_led_ff <= 1'b0;
      err_n_ff <= 1'b1;
    end else if (ce_i) begin
      err_led_ff <= (|excess) | (|enc_fail_i) | abort_pin_act | watchdog_i;
      err_n_ff <= ~((|excess) | (|enc_fail_i) | abort_pin_act | watchdog_i);
    end
  end

  // ----------------------------------------
  // handler dispatch
  // ----------------------------------------
  afp_hstate_t hst_ff;
  afp_hstate_t nxt_hst;
  logic [AFP_AXES-1:0] lim_pend_ff;  // axes that triggered limit handler
  logic err_cause;
  assign err_cause = (|excess) | (|enc_fail_i) | abort_pin_act;

  // one handler at a time; amplifier lockout has priority
  always_comb begin
    nxt_hst = hst_ff;
    case (hst_ff)
      AFP_H_IDLE: begin
        if (lock_kill) begin
          nxt_hst = AFP_H_AMP;
        end else if (err_cause) begin
          nxt_hst = AFP_H_POS_ERROR_HANDLER;
        end else if (|(hit_fwd | hit_rev)) begin
          nxt_hst = AFP_H_LIMIT;
        end
      end
      AFP_H_POS_ERROR_HANDLER: begin
        if (ret_cmd_ff) begin
          nxt_hst = err_cause ? AFP_H_POS_ERROR_HANDLER : AFP_H_IDLE;
        end
      end
      AFP_H_LIMIT, AFP_H_AMP: begin
        if (ret_cmd_ff) begin
          nxt_hst = AFP_H_IDLE;
        end
      end
      default: nxt_hst = AFP_H_IDLE;
    endcase
  end

  // handler state and limit axis record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hst_ff <= AFP_H_IDLE;
      lim_pend_ff <= '0;
    end else if (ce_i) begin
      hst_ff <= nxt_hst;
      if (hst_ff == AFP_H_IDLE && nxt_hst == AFP_H_LIMIT) begin
        lim_pend_ff <= hit_fwd | hit_rev;
      end else if (nxt_hst == AFP_H_IDLE) begin
        lim_pend_ff <= '0;
      end
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic wb_req;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      AFP_REG_CTRL: begin
        rd_mux[AFP_CTRL_FPOL] = fpol_ff;
        rd_mux[AFP_CTRL_RPOL] = rpol_ff;
        rd_mux[AFP_CTRL_SOFTEN] = soften_ff;
        rd_mux[AFP_CTRL_LOCK] = lock_ff;
      end
      AFP_REG_STATUS: rd_mux = {8'h00, amp_en_ff, excess, rev_act, fwd_act,
                                3'h0, err_led_ff, 2'h0, hst_ff};
      AFP_REG_HANDLER: rd_mux = {24'h00_0000, lim_pend_ff, 4'h0};
      AFP_REG_AXSEL: rd_mux = {30'h0000_0000, axsel_ff};
      AFP_REG_ERRLIM: rd_mux = errlim_ff[axsel_ff];
      AFP_REG_SOFTFWD: rd_mux = softfwd_ff[axsel_ff];
      AFP_REG_SOFTREV: rd_mux = softrev_ff[axsel_ff];
      AFP_REG_ERRRD: rd_mux = abs_err[axsel_ff];
      AFP_REG_OFFERR: rd_mux = {30'h0000_0000, oe_ff[axsel_ff]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= wb_req;
      if (wb_req && !wb_we_i) begin
        dat_ff <= rd_mux;
      end
    end
  end

  // register writes; command bits pulse for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpol_ff <= 1'b0;
      rpol_ff <= 1'b0;
      soften_ff <= 1'b0;
      lock_ff <= 1'b0;
      abort_cmd_ff <= 1'b0;
      servo_cmd_ff <= '0;
      ret_cmd_ff <= 1'b0;
      axsel_ff <= 2'h0;
      for (int i = 0; i < AFP_AXES; i++) begin
        errlim_ff[i] <= AFP_ERRLIM_RST;
        softfwd_ff[i] <= AFP_SOFTFWD_RST;
        softrev_ff[i] <= AFP_SOFTREV_RST;
        oe_ff[i] <= AFP_OFFERR_RST;
      end
    end else if (ce_i) begin
      abort_cmd_ff <= 1'b0;
      servo_cmd_ff <= '0;
      ret_cmd_ff <= 1'b0;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          AFP_REG_CTRL: begin
            if (wb_sel_i[0]) begin
              fpol_ff <= wb_dat_i[AFP_CTRL_FPOL];
              rpol_ff <= wb_dat_i[AFP_CTRL_RPOL];
              abort_cmd_ff <= wb_dat_i[AFP_CTRL_ABORT];
              soften_ff <= wb_dat_i[AFP_CTRL_SOFTEN];
            end
            if (wb_sel_i[1]) begin
              servo_cmd_ff <= wb_dat_i[AFP_CTRL_SERVO +: AFP_AXES];
              ret_cmd_ff <= wb_dat_i[AFP_CTRL_RET];
              lock_ff <= wb_dat_i[AFP_CTRL_LOCK];
            end
          end
          AFP_REG_AXSEL: if (wb_sel_i[0]) axsel_ff <= wb_dat_i[1:0];
          AFP_REG_ERRLIM: errlim_ff[axsel_ff] <=
            (errlim_ff[axsel_ff] & ~wmask) | (wb_dat_i & wmask);
          AFP_REG_SOFTFWD: softfwd_ff[axsel_ff] <=
            (softfwd_ff[axsel_ff] & ~wmask) | (wb_dat_i & wmask);
          AFP_REG_SOFTREV: softrev_ff[axsel_ff] <=
            (softrev_ff[axsel_ff] & ~wmask) | (wb_dat_i & wmask);
          AFP_REG_OFFERR: if (wb_sel_i[0]) oe_ff[axsel_ff] <= wb_dat_i[1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign target_acc_o = acc_ff;
  assign target_rej_o = rej_ff;
  assign inhibit_fwd_o = inh_fwd_ff;
  assign inhibit_rev_o = inh_rev_ff;
  assign decel_stop_o = decel_ff;
  assign hard_stop_o = hard_ff;
  assign amp_enable_out_o = amp_en_ff;
  assign error_n_o = err_n_ff;
  assign error_led_o = err_led_ff;
  assign amp_kill_o = amp_kill_ff;

endmodule : afp_top
`default_nettype wire

// ===== afp_top_tb.sv
// testbench: fault supervisor against switch and encoder models
`timescale 1ns/1ps
`default_nettype none
module afp_top_tb;
  import afp_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, abort_n_i = 1, watchdog_i = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, error_n_o, error_led_o, amp_kill_o;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0, enc_fail_i = '0, target_vld_i = '0, move_fwd_i = '0, move_rev_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, lag = '0, t, r;
  logic [127:0] cmd_pos_i = '0, target_i = '0, enc_pos_i;
  logic [3:0] fwd_limit_i, rev_limit_i, target_acc_o, target_rej_o, inhibit_fwd_o;
  logic [3:0] inhibit_rev_o, decel_stop_o, hard_stop_o, amp_enable_out_o;
  int miscompares = 0, checks_done = 0, cycles = 0;
  integer seed = 99;
  logic [63:0] rq[$], e;
  logic tq[$];
  afp_top i_afp_top (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .fwd_limit_i, .rev_limit_i, .abort_n_i,
    .enc_fail_i, .watchdog_i, .cmd_pos_i, .enc_pos_i, .target_i, .target_vld_i, .move_fwd_i,
    .move_rev_i, .target_acc_o, .target_rej_o, .inhibit_fwd_o, .inhibit_rev_o, .decel_stop_o,
    .hard_stop_o, .amp_enable_out_o, .error_n_o, .error_led_o, .amp_kill_o);
  afp_partner i_afp_partner (.clk_i, .cmd_pos_i, .amp_en_i(amp_enable_out_o), .lag_i(lag),
    .enc_pos_o(enc_pos_i), .fwd_limit_o(fwd_limit_i), .rev_limit_o(rev_limit_i));
  initial forever #4 clk_i = ~clk_i;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // classic single cycle; reads note {mask, expected} for the monitor
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hF};
    if (!w) rq.push_back({m, d & m});
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  // monitor: oldest note against each result; also the hang limit
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim;
    end
    if (wb_ack_o && !wb_we_i) begin
      e = rq.pop_front();
      chk(wb_dat_o & e[63:32], e[31:0]);
    end
    if (target_acc_o[0] | target_rej_o[0]) chk(target_acc_o[0], tq.pop_front());
  end
  initial begin
    idle(8);
    rst_i <= 0;
    bus(0, AFP_REG_ERRLIM, AFP_ERRLIM_RST, '1);
    bus(0, AFP_REG_SOFTFWD, AFP_SOFTFWD_RST, '1);
    bus(0, AFP_REG_OFFERR, 0, 3);
    bus(0, 8'h30, 0, '1);
    bus(0, AFP_REG_STATUS, 0, 32'h00F0_0000);
    r = $random(seed);
    bus(1, AFP_REG_ERRLIM, r, 0);
    bus(0, AFP_REG_ERRLIM, r, '1);
    bus(1, AFP_REG_ERRLIM, 32'h0000_0064, 0);
    bus(1, AFP_REG_OFFERR, 1, 0);
    bus(1, AFP_REG_CTRL, 32'h0000_0F00, 0);
    bus(0, AFP_REG_STATUS, 32'h00F0_0000, 32'h00F0_0000);
    lag <= 32'h0000_0065;
    idle(12);
    bus(0, AFP_REG_STATUS, 32'h00E1_0011, 32'h00FF_0013);
    bus(0, AFP_REG_ERRRD, 32'h0000_0065, '1);
    lag <= 0;
    bus(1, AFP_REG_CTRL, 32'h0000_1000, 0);
    bus(0, AFP_REG_STATUS, 32'h00E0_0001, 32'h00F0_0003);
    // profiler takes up the coasted position, error gone
    cmd_pos_i[31:0] <= 32'hFFFF_FF9B;
    bus(1, AFP_REG_CTRL, 32'h0000_0100, 0);
    idle(4);
    bus(1, AFP_REG_CTRL, 32'h0000_1000, 0);
    idle(4);
    bus(0, AFP_REG_STATUS, 32'h00F0_0000, 32'h00F0_0013);
    bus(1, AFP_REG_AXSEL, 1, 0);
    bus(1, AFP_REG_OFFERR, 2, 0);
    move_fwd_i <= 4'b0010;
    move_rev_i <= 4'b1100;
    cmd_pos_i[32 +: 96] <= {32'hFFFF_F700, 32'h0000_0900, 32'h0000_0900};
    idle(12);
    chk(decel_stop_o[1], 1);
    chk(decel_stop_o[3], 1);
    chk(inhibit_fwd_o[2], 1);
    chk(inhibit_rev_o[3], 1);
    bus(0, AFP_REG_HANDLER, 32'h0000_00A0, 32'h0000_00F0);
    bus(0, AFP_REG_STATUS, 32'h00D0_8600, 32'h00F0_FF00);
    bus(1, AFP_REG_CTRL, 1, 0);
    idle(6);
    bus(0, AFP_REG_STATUS, 32'h0000_0900, 32'h0000_0F00);
    bus(1, AFP_REG_AXSEL, 0, 0);
    bus(1, AFP_REG_SOFTFWD, 32'h0000_03E8, 0);
    bus(1, AFP_REG_SOFTREV, 32'hFFFF_FC18, 0);
    bus(1, AFP_REG_CTRL, 32'h0000_0008, 0);
    for (int i = 0; i < 9; i++) begin
      t = (i == 0) ? 32'sh0000_03E8 : $random(seed) % 2048;
      @(posedge clk_i);
      target_i[31:0] <= t;
      target_vld_i[0] <= 1;
      tq.push_back($signed(t) <= 1000 && $signed(t) >= -1000);
      @(posedge clk_i);
      target_vld_i[0] <= 0;
    end
    move_fwd_i <= 4'b0001;
    cmd_pos_i[31:0] <= 32'h0000_044C;
    idle(6);
    chk(inhibit_fwd_o[0], 1);
    chk(decel_stop_o[0], 1);
    watchdog_i <= 1;
    idle(1);
    watchdog_i <= 0;
    bus(0, AFP_REG_STATUS, 0, 32'h00F0_0000);
    abort_n_i <= 0;
    idle(10);
    chk(hard_stop_o, 4'hF);
    chk(error_n_o, 0);
    // lockout fitted while abort low: return, then amp handler
    bus(1, AFP_REG_CTRL, 32'h0000_3000, 0);
    bus(0, AFP_REG_STATUS, 32'h0000_0003, 32'h0000_0003);
    chk(amp_kill_o, 1);
    abort_n_i <= 1;
    idle(4);
    end_sim;
  end
endmodule : afp_top_tb
bind afp_top afp_assertions i_afp_assertions (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .abort_n_i, .watchdog_i, .fwd_limit_i,
  .target_vld_i, .target_acc_o, .target_rej_o, .inhibit_fwd_o, .hard_stop_o,
  .amp_enable_out_o, .error_n_o, .error_led_o);
`default_nettype wire
